//--- src/lss_load_ctrl.sv
// load shedding, dummy load and step increase/decrease supervisor with an axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
module lss_load_ctrl (
    // clock, reset and enable
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       ce,
    // measured generator active power
    input  wire logic [lss_pkg::PWR_W-1:0]  measPower,
    // axi4-lite write address
    input  wire logic [lss_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // axi4-lite read address
    input  wire logic [lss_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // dedicated outputs
    output logic                            shedRelay,
    output logic                            dummyLoad,
    output logic                            stepInc,
    output logic                            stepDec,
    // mapped general purpose outputs
    output logic [lss_pkg::NUM_GPO-1:0]     gpOut
);
    // read mux shared by the read path and the byte-merge of writes
    function automatic logic [32:0] regRead(
        input logic [lss_pkg::ADDR_W-1:0] addr,
        input lss_pkg::lss_cfg_t          cfg,
        input logic [31:0]                status,
        input logic [lss_pkg::PWR_W-1:0]  power
    );
        logic [32:0] res;
        res = {1'b1, 32'h0000_0000};
        case (addr)
            lss_pkg::OFS_HIGH:   res[lss_pkg::PWR_W-1:0] = cfg.high;
            lss_pkg::OFS_LOW:    res[lss_pkg::PWR_W-1:0] = cfg.low;
            lss_pkg::OFS_SAME:   res[31:0] = cfg.sameDly;
            lss_pkg::OFS_OPP:    res[31:0] = cfg.oppDly;
            lss_pkg::OFS_MAP:    res[lss_pkg::MAP_W-1:0] = cfg.outMap;
            lss_pkg::OFS_STATUS: res[31:0] = status;
            lss_pkg::OFS_POWER:  res[lss_pkg::PWR_W-1:0] = power;
            default:             res[32] = 1'b0;
        endcase
        return res;
    endfunction

    function automatic logic [31:0] mergeBytes(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // one step direction: request, hold-off while a timer runs, active until released
    function automatic lss_pkg::lss_step_t stepNext(
        input lss_pkg::lss_step_t cur,
        input logic               want,
        input logic               release_,
        input logic               allowed
    );
        lss_pkg::lss_step_t res;
        res = cur;
        case (cur)
            lss_pkg::STP_IDLE: begin
                if (want) begin
                    res = allowed ? lss_pkg::STP_ACT : lss_pkg::STP_HOLD;
                end
            end
            lss_pkg::STP_HOLD: begin
                if (!want) begin
                    res = lss_pkg::STP_IDLE;
                end else if (allowed) begin
                    res = lss_pkg::STP_ACT;
                end
            end
            lss_pkg::STP_ACT: begin
                if (release_) begin
                    res = lss_pkg::STP_IDLE;
                end
            end
            default: res = lss_pkg::STP_IDLE;
        endcase
        return res;
    endfunction

    // register bus state
    lss_pkg::lss_cfg_t         cfg_r;
    lss_pkg::lss_cfg_t         cfg_nxt;
    logic                      awHave_r;
    logic                      awHave_nxt;
    logic                      wHave_r;
    logic                      wHave_nxt;
    logic [lss_pkg::ADDR_W-1:0] awAddr_r;
    logic [lss_pkg::ADDR_W-1:0] awAddr_nxt;
    logic [31:0]               wData_r;
    logic [31:0]               wData_nxt;
    logic [3:0]                wStrb_r;
    logic [3:0]                wStrb_nxt;
    logic                      bValid_r;
    logic                      bValid_nxt;
    logic [1:0]                bResp_r;
    logic [1:0]                bResp_nxt;
    logic                      rValid_r;
    logic                      rValid_nxt;
    logic [31:0]               rData_r;
    logic [31:0]               rData_nxt;
    logic [1:0]                rResp_r;
    logic [1:0]                rResp_nxt;
    logic [32:0]               wOld;
    logic [32:0]               rLook;
    logic [31:0]               wMerged;

    // supervision state
    logic                      shed_r;
    logic                      shed_nxt;
    lss_pkg::lss_step_t        incSt_r;
    lss_pkg::lss_step_t        incSt_nxt;
    lss_pkg::lss_step_t        decSt_r;
    lss_pkg::lss_step_t        decSt_nxt;
    logic [31:0]               status;
    logic                      aboveHigh;
    logic                      belowHigh;
    logic                      aboveLow;
    logic                      belowLow;
    logic                      incEnd;
    logic                      decEnd;
    logic                      incSameDone;
    logic                      decSameDone;
    logic                      afterIncDone;
    logic                      afterDecDone;
    lss_pkg::lss_sig_t         sig;

    // threshold compares, unsigned power
    assign aboveHigh = (measPower > cfg_r.high);
    assign belowHigh = (measPower < cfg_r.high);
    assign aboveLow  = (measPower > cfg_r.low);
    assign belowLow  = (measPower < cfg_r.low);

    // ready is withheld while frozen so no handshake is lost
    assign s_axi_awready = ce && !awHave_r && !bValid_r;
    assign s_axi_wready  = ce && !wHave_r && !bValid_r;
    assign s_axi_arready = ce && !rValid_r;

    assign wOld    = regRead(awAddr_r, cfg_r, status, measPower);
    assign rLook   = regRead(s_axi_araddr, cfg_r, status, measPower);
    assign wMerged = mergeBytes(wOld[31:0], wData_r, wStrb_r);

    always_comb begin
        awHave_nxt = awHave_r;
        wHave_nxt  = wHave_r;
        awAddr_nxt = awAddr_r;
        wData_nxt  = wData_r;
        wStrb_nxt  = wStrb_r;
        bValid_nxt = bValid_r;
        bResp_nxt  = bResp_r;
        rValid_nxt = rValid_r;
        rData_nxt  = rData_r;
        rResp_nxt  = rResp_r;
        cfg_nxt    = cfg_r;
        if (s_axi_awvalid && s_axi_awready) begin
            awHave_nxt = 1'b1;
            awAddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHave_nxt = 1'b1;
            wData_nxt = s_axi_wdata;
            wStrb_nxt = s_axi_wstrb;
        end
        // address and data both held: commit and raise the answer on the same edge
        if (awHave_r && wHave_r) begin
            awHave_nxt = 1'b0;
            wHave_nxt  = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt  = wOld[32] ? lss_pkg::RESP_OKAY : lss_pkg::RESP_SLVERR;
            case (awAddr_r)
                lss_pkg::OFS_HIGH: cfg_nxt.high    = wMerged[lss_pkg::PWR_W-1:0];
                lss_pkg::OFS_LOW:  cfg_nxt.low     = wMerged[lss_pkg::PWR_W-1:0];
                lss_pkg::OFS_SAME: cfg_nxt.sameDly = wMerged;
                lss_pkg::OFS_OPP:  cfg_nxt.oppDly  = wMerged;
                lss_pkg::OFS_MAP:  cfg_nxt.outMap  = wMerged[lss_pkg::MAP_W-1:0];
                default:           cfg_nxt = cfg_r;
            endcase
        end
        if (bValid_r && s_axi_bready) begin
            bValid_nxt = 1'b0;
        end
        if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_nxt = 1'b1;
            rData_nxt  = rLook[31:0];
            rResp_nxt  = rLook[32] ? lss_pkg::RESP_OKAY : lss_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_r    <= '{high: lss_pkg::RST_HIGH, low: lss_pkg::RST_LOW, sameDly: lss_pkg::RST_SAME,
                          oppDly: lss_pkg::RST_OPP, outMap: lss_pkg::RST_MAP};
            awHave_r <= 1'b0;
            wHave_r  <= 1'b0;
            awAddr_r <= '0;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r  <= lss_pkg::RESP_OKAY;
            rValid_r <= 1'b0;
            rData_r  <= 32'h0000_0000;
            rResp_r  <= lss_pkg::RESP_OKAY;
        end else if (ce) begin
            cfg_r    <= cfg_nxt;
            awHave_r <= awHave_nxt;
            wHave_r  <= wHave_nxt;
            awAddr_r <= awAddr_nxt;
            wData_r  <= wData_nxt;
            wStrb_r  <= wStrb_nxt;
            bValid_r <= bValid_nxt;
            bResp_r  <= bResp_nxt;
            rValid_r <= rValid_nxt;
            rData_r  <= rData_nxt;
            rResp_r  <= rResp_nxt;
        end
    end

    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp  = bResp_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata  = rData_r;
    assign s_axi_rresp  = rResp_r;

    // shedding has no enable bit at all; software can only keep it off through the thresholds, e.g. high at its 16'hffff reset value
    always_comb begin
        shed_nxt = shed_r;
        if (aboveHigh) begin
            shed_nxt = 1'b1;
        end else if (belowLow) begin
            shed_nxt = 1'b0;
        end
    end

    // a pulse may start only when its own-direction and opposite-direction timers are both done
    always_comb begin
        incSt_nxt = stepNext(incSt_r, belowLow, aboveLow, incSameDone && afterDecDone);
        decSt_nxt = stepNext(decSt_r, aboveHigh, belowHigh, decSameDone && afterIncDone);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shed_r  <= 1'b0;
            incSt_r <= lss_pkg::STP_IDLE;
            decSt_r <= lss_pkg::STP_IDLE;
        end else if (ce) begin
            shed_r  <= shed_nxt;
            incSt_r <= incSt_nxt;
            decSt_r <= decSt_nxt;
        end
    end

    // timers load on the cycle a pulse ends
    assign incEnd = (incSt_r == lss_pkg::STP_ACT) && (incSt_nxt != lss_pkg::STP_ACT);
    assign decEnd = (decSt_r == lss_pkg::STP_ACT) && (decSt_nxt != lss_pkg::STP_ACT);

    lss_delay_timer uIncSame (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .start   (incEnd),
        .loadVal (cfg_r.sameDly),
        .expired (incSameDone)
    );

    lss_delay_timer uDecSame (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .start   (decEnd),
        .loadVal (cfg_r.sameDly),
        .expired (decSameDone)
    );

    lss_delay_timer uAfterInc (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .start   (incEnd),
        .loadVal (cfg_r.oppDly),
        .expired (afterIncDone)
    );

    lss_delay_timer uAfterDec (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .start   (decEnd),
        .loadVal (cfg_r.oppDly),
        .expired (afterDecDone)
    );

    assign shedRelay = shed_r;
    assign dummyLoad = !shed_r;
    assign stepInc   = (incSt_r == lss_pkg::STP_ACT);
    assign stepDec   = (decSt_r == lss_pkg::STP_ACT);

    // the external bank closes the loop by moving power back across the threshold
    assign sig.shed    = shedRelay;
    assign sig.dummy   = dummyLoad;
    assign sig.stepInc = stepInc;
    assign sig.stepDec = stepDec;

    always_comb begin
        status = 32'h0000_0000;
        status[lss_pkg::ST_SHED_BIT]  = shed_r;
        status[lss_pkg::ST_DUMMY_BIT] = !shed_r;
        status[lss_pkg::ST_INC_BIT]   = stepInc;
        status[lss_pkg::ST_DEC_BIT]   = stepDec;
        status[lss_pkg::ST_IHOLD_BIT] = (incSt_r == lss_pkg::STP_HOLD);
        status[lss_pkg::ST_DHOLD_BIT] = (decSt_r == lss_pkg::STP_HOLD);
    end

    lss_out_map uOutMap (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .sig     (sig),
        .outMap  (cfg_r.outMap),
        .gpOut   (gpOut)
    );
endmodule
`default_nettype wire

//--- src/lss_pkg.sv
// constants, register map and carrier types for the load shed and step controller
package lss_pkg;
    localparam int unsigned PWR_W   = 16;
    localparam int unsigned DLY_W   = 32;
    localparam int unsigned NUM_GPO = 8;
    localparam int unsigned SEL_W   = 3;
    localparam int unsigned MAP_W   = NUM_GPO * SEL_W;
    localparam int unsigned ADDR_W  = 8;

    localparam logic [ADDR_W-1:0] OFS_HIGH   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LOW    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SAME   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OPP    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_MAP    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_POWER  = 8'h18;

    localparam logic [PWR_W-1:0] RST_HIGH = 16'hffff;
    localparam logic [PWR_W-1:0] RST_LOW  = 16'h0000;
    localparam logic [DLY_W-1:0] RST_SAME = 32'h0000_0100;
    localparam logic [DLY_W-1:0] RST_OPP  = 32'h0000_0100;
    localparam logic [MAP_W-1:0] RST_MAP  = 24'h00_0000;

    localparam int unsigned ST_SHED_BIT  = 0;
    localparam int unsigned ST_DUMMY_BIT = 1;
    localparam int unsigned ST_INC_BIT   = 2;
    localparam int unsigned ST_DEC_BIT   = 3;
    localparam int unsigned ST_IHOLD_BIT = 4;
    localparam int unsigned ST_DHOLD_BIT = 5;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [SEL_W-1:0] {
        FN_OFF   = 3'b000,
        FN_SHED  = 3'b001,
        FN_DUMMY = 3'b010,
        FN_INC   = 3'b011,
        FN_DEC   = 3'b100
    } lss_fn_t;

    typedef enum logic [1:0] {
        STP_IDLE = 2'b00,
        STP_HOLD = 2'b01,
        STP_ACT  = 2'b10
    } lss_step_t;

    typedef struct packed {
        logic [PWR_W-1:0] high;
        logic [PWR_W-1:0] low;
        logic [DLY_W-1:0] sameDly;
        logic [DLY_W-1:0] oppDly;
        logic [MAP_W-1:0] outMap;
    } lss_cfg_t;

    typedef struct packed {
        logic shed;
        logic dummy;
        logic stepInc;
        logic stepDec;
    } lss_sig_t;
endpackage

//--- src/lss_delay_timer.sv
// down-counting protection delay timer, loaded at the end of a pulse
`timescale 1ns/10ps
`default_nettype none
module lss_delay_timer (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     ce,
    // control
    input  wire logic                     start,
    input  wire logic [lss_pkg::DLY_W-1:0] loadVal,
    // status
    output logic                          expired
);
    logic [lss_pkg::DLY_W-1:0] cnt_r;
    logic [lss_pkg::DLY_W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = loadVal;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expired = (cnt_r == '0);
endmodule
`default_nettype wire

//--- src/lss_out_map.sv
// routes the shed, dummy and step signals onto the general purpose outputs
`timescale 1ns/10ps
`default_nettype none
module lss_out_map (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      ce,
    // sources and selection
    input  wire lss_pkg::lss_sig_t         sig,
    input  wire logic [lss_pkg::MAP_W-1:0] outMap,
    // outputs
    output logic [lss_pkg::NUM_GPO-1:0]    gpOut
);
    logic [lss_pkg::NUM_GPO-1:0] gpo_r;
    logic [lss_pkg::NUM_GPO-1:0] gpo_nxt;

    always_comb begin
        gpo_nxt = '0;
        for (int i = 0; i < lss_pkg::NUM_GPO; i++) begin
            case (lss_pkg::lss_fn_t'(outMap[i*lss_pkg::SEL_W +: lss_pkg::SEL_W]))
                lss_pkg::FN_SHED:  gpo_nxt[i] = sig.shed;
                lss_pkg::FN_DUMMY: gpo_nxt[i] = sig.dummy;
                lss_pkg::FN_INC:   gpo_nxt[i] = sig.stepInc;
                lss_pkg::FN_DEC:   gpo_nxt[i] = sig.stepDec;
                default:           gpo_nxt[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gpo_r <= '0;
        end else if (ce) begin
            gpo_r <= gpo_nxt;
        end
    end

    assign gpOut = gpo_r;
endmodule
`default_nettype wire

//--- verification/lss_load_ctrl_props.sv
// port assertions for the load shed and step controller
`timescale 1ns/10ps
`default_nettype none
module lss_load_ctrl_props (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       ce,
    // bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    // supervision outputs
    input wire logic       shedRelay,
    input wire logic       dummyLoad,
    input wire logic       stepInc,
    input wire logic       stepDec,
    input wire logic [7:0] gpOut
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    reset_rest_a: assert property ($fell(rst) |-> !shedRelay && dummyLoad && !stepInc && !stepDec && !gpOut)
        else $error("outputs not at rest after reset");
    dummy_inv_a: assert property (dummyLoad == !shedRelay)
        else $error("dummy load not inverse of shed");
    dec_shed_a: assert property ($rose(stepDec) |-> shedRelay)
        else $error("decrease raised without shed");
    inc_clear_a: assert property ($rose(stepInc) |-> !shedRelay)
        else $error("increase raised while shed");
    ce_freeze_a: assert property (!ce |-> !s_axi_awready && !s_axi_arready ##1 $stable(shedRelay) && $stable(stepDec))
        else $error("state moved with enable low");
    busy_refuse_a: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
        else $error("request accepted while answer pending");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    resp_taken_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");
endmodule
bind lss_load_ctrl lss_load_ctrl_props props (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .shedRelay(shedRelay), .dummyLoad(dummyLoad), .stepInc(stepInc),
    .stepDec(stepDec), .gpOut(gpOut)
);
`default_nettype wire

//--- verification/lss_load_bank.sv
// load bank model: moves measured power while a step request is held
`timescale 1ns/10ps
`default_nettype none
module lss_load_bank (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // requests and bench override
    input  wire logic        stepInc,
    input  wire logic        stepDec,
    input  wire logic        setEn,
    input  wire logic        slow,
    input  wire logic [15:0] setVal,
    // power seen by the controller
    output logic [15:0]      measPower
);
    logic [1:0] pace_r;
    // slow mode takes one step in four cycles, like a lagging bank
    always_ff @(posedge clk_sys) begin
        pace_r <= rst ? 2'h0 : pace_r + 2'h1;
        if (setEn)
            measPower <= setVal;
        else if (!slow || pace_r == 2'h0)
            measPower <= measPower + (stepInc ? 16'h0020 : 16'h0000) - (stepDec ? 16'h0020 : 16'h0000);
    end
endmodule
`default_nettype wire

//--- verification/load_shed_step_control_bench.sv
// self-checking bench for the load shed and step controller
`timescale 1ns/10ps
`default_nettype none
module load_shed_step_control_bench;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} lss_row_t;
    logic        clk_sys, rst, ce, setEn, slow, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, shedRelay, dummyLoad, stepInc, stepDec;
    logic [1:0]  bresp, rresp, rs;
    logic [7:0]  awaddr, araddr, gpOut;
    logic [15:0] setVal, measPower;
    logic [31:0] wdata, rdata, rd;
    int          failures, tests_run, cycles;
    lss_row_t    rows [16];

    lss_load_ctrl dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .measPower(measPower), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .shedRelay(shedRelay), .dummyLoad(dummyLoad),
        .stepInc(stepInc), .stepDec(stepDec), .gpOut(gpOut)
    );
    lss_load_bank bank (.clk_sys(clk_sys), .rst(rst), .stepInc(stepInc), .stepDec(stepDec),
        .setEn(setEn), .slow(slow), .setVal(setVal), .measPower(measPower));

    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic setPwr(input logic [15:0] v);
        @(posedge clk_sys);
        {setEn, setVal} <= {1'h1, v};
    endtask
    // bounded, so a stuck request ends as a mismatch instead of a hang
    task automatic waitStep(input logic dec, input logic v, input int lim);
        for (int n = 0; n < lim && (dec ? stepDec : stepInc) !== v; n++)
            tick(1);
        if ((dec ? stepDec : stepInc) !== v)
            failures++;
    endtask
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic ga, gw, gr, gd;
        gd = 1'h0;
        @(posedge clk_sys);
        if (wr)
            {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        else
            {araddr, arvalid, rready} <= {a, 2'h3};
        for (int n = 0; n < 50 && !gd; n++) begin
            @(negedge clk_sys);
            {ga, gw, gr} = {awvalid & awready, wvalid & wready, arvalid & arready};
            {gd, rs, rd} = wr ? {bvalid, bresp, 32'h0} : {rvalid, rresp, rdata};
            @(posedge clk_sys);
            {awvalid, wvalid, arvalid} <= {awvalid & ~ga, wvalid & ~gw, arvalid & ~gr};
        end
        // an unanswered request counts against the run instead of leaving stale data
        if (!gd)
            failures++;
        {bready, rready} <= 2'h0;
    endtask
    task automatic results();
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {rst, ce, setEn, slow, awvalid, wvalid, bready, arvalid, rready} = 9'h1c0;
        {setVal, awaddr, araddr, wdata} = {16'h02bc, 48'h0};
        rows = '{'{1'h0, 8'h00, 32'hffff, 2'h0}, '{1'h0, 8'h04, 32'h0, 2'h0}, '{1'h0, 8'h08, 32'h100, 2'h0},
            '{1'h0, 8'h0c, 32'h100, 2'h0}, '{1'h0, 8'h10, 32'h0, 2'h0}, '{1'h1, 8'h00, 32'h123403e8, 2'h0},
            '{1'h0, 8'h00, 32'h3e8, 2'h0}, '{1'h1, 8'h04, 32'h190, 2'h0}, '{1'h1, 8'h08, 32'h4, 2'h0},
            '{1'h1, 8'h0c, 32'h4, 2'h0}, '{1'h1, 8'h10, 32'h8d1, 2'h0}, '{1'h0, 8'h10, 32'h8d1, 2'h0},
            '{1'h1, 8'h14, 32'hff, 2'h0}, '{1'h0, 8'h14, 32'h2, 2'h0}, '{1'h1, 8'h1c, 32'h5, 2'h2},
            '{1'h0, 8'h1c, 32'h0, 2'h2}};
        repeat (20) @(posedge clk_sys);
        rst <= 1'h0;
        tick(1);
        chk("rest", {shedRelay, dummyLoad, stepInc, stepDec, gpOut}, 12'h400);
        foreach (rows[i]) begin
            axi(rows[i].wr, rows[i].a, rows[i].d);
            chk("resp", rs, rows[i].r);
            if (!rows[i].wr)
                chk("rdata", rd, rows[i].d);
        end
        setPwr(16'h04b0);
        tick(2);
        chk("shed dummy dec", {shedRelay, dummyLoad, stepDec}, 3'h5);
        tick(1);
        chk("mapped", gpOut, 8'h09);
        setPwr(16'h02bc);
        tick(2);
        chk("hold", {shedRelay, stepDec}, 2'h2);
        setPwr(16'h012c);
        tick(2);
        chk("held off", {shedRelay, stepInc}, 2'h0);
        waitStep(1'h0, 1'h1, 20);
        chk("inc", stepInc, 1'h1);
        tick(1);
        chk("mapped", gpOut, 8'h06);
        setPwr(16'h0190);
        tick(3);
        chk("at low", stepInc, 1'h1);
        setPwr(16'h01f4);
        tick(2);
        chk("inc end", stepInc, 1'h0);
        setPwr(16'h012c);
        tick(2);
        chk("same gap", stepInc, 1'h0);
        waitStep(1'h0, 1'h1, 20);
        chk("inc again", stepInc, 1'h1);
        @(posedge clk_sys);
        setEn <= 1'h0;
        waitStep(1'h0, 1'h0, 40);
        axi(1'h0, 8'h18, 32'h0);
        chk("raised", rd > 32'h190 && rd < 32'h3e8, 1'h1);
        setPwr(16'h04b0);
        waitStep(1'h1, 1'h1, 40);
        @(posedge clk_sys);
        {setEn, slow} <= 2'h1;
        waitStep(1'h1, 1'h0, 200);
        axi(1'h0, 8'h18, 32'h0);
        chk("lowered", rd > 32'h190 && rd < 32'h3e8 && shedRelay, 1'h1);
        @(posedge clk_sys);
        ce <= 1'h0;
        setPwr(16'h012c);
        tick(4);
        chk("frozen", shedRelay, 1'h1);
        @(posedge clk_sys);
        ce <= 1'h1;
        tick(2);
        chk("thawed", shedRelay, 1'h0);
        @(posedge clk_sys);
        rst <= 1'h1;
        tick(2);
        @(posedge clk_sys);
        rst <= 1'h0;
        tick(1);
        chk("rest again", {shedRelay, dummyLoad, stepInc, stepDec, gpOut}, 12'h400);
        results();
    end
endmodule
`default_nettype wire
